//--- rtl/pts_pkg.sv
// Package of constants and types for the peripheral trigger sequencer
package pts_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;
  localparam int QUEUE_DEPTH = 16;
  localparam int NUM_IN = 16;
  localparam int NUM_OUT = 16;
  // Register offsets
  localparam logic [5:0] CTRL_OFS = 6'h00;
  localparam logic [5:0] STATUS_OFS = 6'h01;
  localparam logic [5:0] EDGE_OFS = 6'h02;
  localparam logic [5:0] T0LIM_OFS = 6'h03;
  localparam logic [5:0] T1LIM_OFS = 6'h04;
  localparam logic [5:0] C0LIM_OFS = 6'h05;
  localparam logic [5:0] C1LIM_OFS = 6'h06;
  localparam logic [5:0] WDOG_OFS = 6'h07;
  localparam logic [5:0] QUEUE_OFS = 6'h10;
  // Control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_RUN_BIT = 1;
  localparam int CTRL_SSTEP_BIT = 2;
  localparam int CTRL_WDEN_BIT = 3;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] WDOG_RESET = 16'hFFFF;
  // Step opcode in bits 7:4, argument in bits 3:0
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_WAIT_T0 = 4'h1;
  localparam logic [3:0] OP_WAIT_T1 = 4'h2;
  localparam logic [3:0] OP_WAIT_IN = 4'h3;
  localparam logic [3:0] OP_TRIG = 4'h4;
  localparam logic [3:0] OP_IRQ = 4'h5;
  localparam logic [3:0] OP_CNT0 = 4'h6;
  localparam logic [3:0] OP_CNT1 = 4'h7;
  localparam logic [3:0] OP_HALT = 4'h8;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC, ST_PAUSE} pts_state_type;
endpackage

//--- rtl/pts_queue_mem.sv
// Step queue memory with registered read port
`timescale 1ns/1ps
module pts_queue_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 8,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic wr_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  // Storage has no reset; software loads it before running
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule

//--- rtl/pts_top.sv
// Top of the peripheral trigger sequencer
`timescale 1ns/1ps
module pts_top (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [pts_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pts_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pts_pkg::DATA_W-1:0] RDATA_O,
  input wire logic [pts_pkg::NUM_IN-1:0] TRIG_IN_I,
  output logic [pts_pkg::NUM_OUT-1:0] TRIG_OUT_O,
  output logic [3:0] IRQ_O,
  output logic STEP_IRQ_O,
  output logic WDOG_IRQ_O
);
  import pts_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [3:0] ctrl;
  logic [15:0] edge_sel;
  logic [15:0] t0_lim;
  logic [15:0] t1_lim;
  logic [15:0] c0_lim;
  logic [15:0] c1_lim;
  logic [15:0] wd_lim;
  logic [3:0] next_ctrl;
  logic [15:0] next_edge_sel;
  logic [15:0] next_t0_lim;
  logic [15:0] next_t1_lim;
  logic [15:0] next_c0_lim;
  logic [15:0] next_c1_lim;
  logic [15:0] next_wd_lim;
  logic running;
  logic halt_req;
  logic wd_fire;

  assign running = ctrl[CTRL_EN_BIT] & ctrl[CTRL_RUN_BIT];

  always_comb begin
    next_ctrl = ctrl;
    next_edge_sel = edge_sel;
    next_t0_lim = t0_lim;
    next_t1_lim = t1_lim;
    next_c0_lim = c0_lim;
    next_c1_lim = c1_lim;
    next_wd_lim = wd_lim;
    if (halt_req || wd_fire) begin
      next_ctrl[CTRL_RUN_BIT] = 1'b0;
    end
    if (WR_I) begin
      unique case (ADDR_I)
        CTRL_OFS: next_ctrl = WDATA_I[3:0];
        EDGE_OFS: next_edge_sel = WDATA_I;
        T0LIM_OFS: begin
          if (!running) begin
            next_t0_lim = WDATA_I;
          end
        end
        T1LIM_OFS: begin
          if (!running) begin
            next_t1_lim = WDATA_I;
          end
        end
        C0LIM_OFS: next_c0_lim = WDATA_I;
        C1LIM_OFS: next_c1_lim = WDATA_I;
        WDOG_OFS: next_wd_lim = WDATA_I;
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= RESET_VALUE[3:0];
      edge_sel <= RESET_VALUE;
      t0_lim <= RESET_VALUE;
      t1_lim <= RESET_VALUE;
      c0_lim <= RESET_VALUE;
      c1_lim <= RESET_VALUE;
      wd_lim <= WDOG_RESET;
    end else begin
      ctrl <= next_ctrl;
      edge_sel <= next_edge_sel;
      t0_lim <= next_t0_lim;
      t1_lim <= next_t1_lim;
      c0_lim <= next_c0_lim;
      c1_lim <= next_c1_lim;
      wd_lim <= next_wd_lim;
    end
  end

  // Queue writes go through only while EN and RUN are not both set so a running step is stable
  logic q_wr;
  logic [3:0] pc;
  logic [7:0] step;
  assign q_wr = WR_I && (ADDR_I[5:4] == QUEUE_OFS[5:4]) && !running;

  pts_queue_mem #(
    .DEPTH(QUEUE_DEPTH),
    .WIDTH(8),
    .AW(4)
  ) u_queue (
    .clk_i(REF_CLK_I),
    .wr_i(q_wr),
    .waddr_i(ADDR_I[3:0]),
    .wdata_i(WDATA_I[7:0]),
    .raddr_i(pc),
    .rdata_o(step)
  );

  // ----------------------------------------------------------------
  // Input edge detection
  // ----------------------------------------------------------------
  logic [NUM_IN-1:0] in_prev;
  logic [NUM_IN-1:0] in_hit;
  // Falling edge when the select bit is 1, rising otherwise
  assign in_hit = ((in_prev & ~TRIG_IN_I) & edge_sel) |
                  ((~in_prev & TRIG_IN_I) & ~edge_sel);

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      in_prev <= '0;
    end else begin
      in_prev <= TRIG_IN_I;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pts_state_type state;
  pts_state_type next_state;
  logic [3:0] next_pc;
  logic [15:0] tmr0;
  logic [15:0] tmr1;
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic [15:0] wd_cnt;
  logic [15:0] next_tmr0;
  logic [15:0] next_tmr1;
  logic [15:0] next_cnt0;
  logic [15:0] next_cnt1;
  logic [15:0] next_wd_cnt;
  logic [NUM_OUT-1:0] next_trig;
  logic [3:0] next_irq;
  logic next_step_irq;
  logic next_wd_irq;
  logic done;
  logic [3:0] op;
  logic [3:0] arg;
  assign op = step[7:4];
  assign arg = step[3:0];

  always_comb begin
    next_state = state;
    next_pc = pc;
    next_tmr0 = tmr0;
    next_tmr1 = tmr1;
    next_cnt0 = cnt0;
    next_cnt1 = cnt1;
    next_wd_cnt = wd_cnt;
    next_trig = '0;
    next_irq = '0;
    next_step_irq = 1'b0;
    next_wd_irq = 1'b0;
    done = 1'b0;
    halt_req = 1'b0;
    wd_fire = 1'b0;
    unique case (state)
      ST_IDLE: begin
        next_pc = 4'h0;
        if (running) begin
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // One cycle for the registered queue read
        next_tmr0 = 16'h0000;
        next_tmr1 = 16'h0000;
        next_wd_cnt = 16'h0000;
        next_state = ST_EXEC;
      end
      ST_EXEC: begin
        next_wd_cnt = wd_cnt + 16'h0001;
        unique case (op)
          OP_WAIT_T0: begin
            if (tmr0 == t0_lim) begin
              done = 1'b1;
            end else begin
              next_tmr0 = tmr0 + 16'h0001;
            end
          end
          OP_WAIT_T1: begin
            if (tmr1 == t1_lim) begin
              done = 1'b1;
            end else begin
              next_tmr1 = tmr1 + 16'h0001;
            end
          end
          OP_WAIT_IN: done = in_hit[arg];
          OP_TRIG: begin
            next_trig[arg] = 1'b1;
            done = 1'b1;
          end
          OP_IRQ: begin
            next_irq[arg[1:0]] = 1'b1;
            done = 1'b1;
          end
          OP_CNT0: begin
            // Loop back to step arg until the counter reaches its limit
            done = 1'b1;
            if (cnt0 == c0_lim) begin
              next_cnt0 = 16'h0000;
            end else begin
              next_cnt0 = cnt0 + 16'h0001;
              next_pc = arg - 4'h1;
            end
          end
          OP_CNT1: begin
            done = 1'b1;
            if (cnt1 == c1_lim) begin
              next_cnt1 = 16'h0000;
            end else begin
              next_cnt1 = cnt1 + 16'h0001;
              next_pc = arg - 4'h1;
            end
          end
          OP_HALT: begin
            halt_req = 1'b1;
            next_state = ST_IDLE;
          end
          default: done = 1'b1;
        endcase
        if (ctrl[CTRL_WDEN_BIT] && !done && wd_cnt == wd_lim) begin
          wd_fire = 1'b1;
          next_wd_irq = 1'b1;
          next_state = ST_IDLE;
        end else if (done) begin
          next_pc = next_pc + 4'h1;
          next_step_irq = ctrl[CTRL_SSTEP_BIT];
          next_state = ctrl[CTRL_SSTEP_BIT] ? ST_PAUSE : ST_FETCH;
        end
      end
      ST_PAUSE: begin
        // Single step: software rewrites run to take the next step
        if (WR_I && ADDR_I == CTRL_OFS && WDATA_I[CTRL_RUN_BIT]) begin
          next_state = ST_FETCH;
        end
      end
    endcase
    if (!running && state != ST_PAUSE) begin
      next_state = ST_IDLE;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      pc <= 4'h0;
      tmr0 <= RESET_VALUE;
      tmr1 <= RESET_VALUE;
      cnt0 <= RESET_VALUE;
      cnt1 <= RESET_VALUE;
      wd_cnt <= RESET_VALUE;
      TRIG_OUT_O <= '0;
      IRQ_O <= 4'h0;
      STEP_IRQ_O <= 1'b0;
      WDOG_IRQ_O <= 1'b0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      tmr0 <= next_tmr0;
      tmr1 <= next_tmr1;
      cnt0 <= next_cnt0;
      cnt1 <= next_cnt1;
      wd_cnt <= next_wd_cnt;
      TRIG_OUT_O <= next_trig;
      IRQ_O <= next_irq;
      STEP_IRQ_O <= next_step_irq;
      WDOG_IRQ_O <= next_wd_irq;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [15:0] next_rdata;
  always_comb begin
    next_rdata = 16'h0000;
    if (RD_I) begin
      unique case (ADDR_I)
        CTRL_OFS: next_rdata = {12'h000, ctrl};
        STATUS_OFS: next_rdata = {8'h00, 2'b00, state, pc};
        EDGE_OFS: next_rdata = edge_sel;
        T0LIM_OFS: next_rdata = t0_lim;
        T1LIM_OFS: next_rdata = t1_lim;
        C0LIM_OFS: next_rdata = c0_lim;
        C1LIM_OFS: next_rdata = c1_lim;
        WDOG_OFS: next_rdata = wd_lim;
        default: next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      RDATA_O <= 16'h0000;
    end else begin
      RDATA_O <= next_rdata;
    end
  end
endmodule

//--- tb/pts_periph_model.sv
// Peripheral-side model: drives trigger inputs and counts sequencer pulses
`timescale 1ns/1ps
module pts_periph_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [15:0] trig_out_i,
  input wire logic [3:0] irq_i,
  input wire logic step_i,
  input wire logic wdog_i,
  output logic [15:0] trig_in_o
);
  // -------------------------------
  // Source levels and event counts
  // -------------------------------
  logic [21:0] ev;
  int tc [22];
  assign ev = {wdog_i, step_i, irq_i, trig_out_i};
  initial trig_in_o = 16'h0000;
  // Level is held until changed, as a real source would
  task automatic set_in(input int b, input logic v);
    trig_in_o[b] <= v;
  endtask
  function automatic int cnt(input int sel);
    return tc[sel];
  endfunction
  always @(posedge clk_i or negedge rst_n_i) begin
    for (int i = 0; i < 22; i++) begin
      tc[i] <= rst_n_i ? tc[i] + int'(ev[i] === 1'b1) : 0;
    end
  end
endmodule

//--- tb/pts_top_asserts.sv
// Port checker for the trigger sequencer, bound to its top
`timescale 1ns/1ps
module pts_top_asserts (
  input wire logic REF_CLK_I,
  input wire logic RST_N_I,
  input wire logic [pts_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [pts_pkg::DATA_W-1:0] RDATA_O,
  input wire logic [pts_pkg::NUM_OUT-1:0] TRIG_OUT_O,
  input wire logic [3:0] IRQ_O,
  input wire logic STEP_IRQ_O,
  input wire logic WDOG_IRQ_O
);
  import pts_pkg::*;
  // -------------------------------
  // Port relations
  // -------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);
  rd_idle_zero_a: assert property (!$past(RD_I) |-> RDATA_O == 16'h0000)
    else $error("read data not zero without a read");
  unmapped_rd_a: assert property (RD_I && ADDR_I > 6'h07 |=> RDATA_O == 16'h0000)
    else $error("unmapped or queue read not zero");
  trig_pulse_a: assert property (|TRIG_OUT_O |=> TRIG_OUT_O == 16'h0000)
    else $error("trigger output longer than one cycle");
  trig_single_a: assert property ($onehot0(TRIG_OUT_O))
    else $error("several triggers at once");
  irq_pulse_a: assert property (|IRQ_O |=> IRQ_O == 4'h0)
    else $error("interrupt longer than one cycle");
  irq_single_a: assert property ($onehot0(IRQ_O) && !(|IRQ_O && |TRIG_OUT_O))
    else $error("two step actions in one cycle");
  step_pulse_a: assert property (STEP_IRQ_O |=> !STEP_IRQ_O)
    else $error("step interrupt longer than one cycle");
  wdog_pulse_a: assert property ($rose(WDOG_IRQ_O) |=> !WDOG_IRQ_O [*3])
    else $error("watchdog interrupt repeated");
  cover property (|TRIG_OUT_O);
  cover property (|IRQ_O);
  cover property (STEP_IRQ_O);
  cover property (WDOG_IRQ_O);
endmodule
bind pts_top pts_top_asserts u_pts_top_asserts (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
  .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .TRIG_OUT_O(TRIG_OUT_O),
  .IRQ_O(IRQ_O), .STEP_IRQ_O(STEP_IRQ_O), .WDOG_IRQ_O(WDOG_IRQ_O));

//--- tb/pts_tb_top.sv
// Self-checking testbench for the trigger sequencer
`timescale 1ns/1ps
module pts_tb_top;
  import pts_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic [NUM_IN-1:0] tin;
  logic [NUM_OUT-1:0] tout;
  logic [3:0] irq;
  logic step_irq;
  logic wdog_irq;
  int bad_count = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  pts_top u_pts_top (.REF_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIG_IN_I(tin), .TRIG_OUT_O(tout),
    .IRQ_O(irq), .STEP_IRQ_O(step_irq), .WDOG_IRQ_O(wdog_irq));
  pts_periph_model u_pts_periph_model (.clk_i(clk), .rst_n_i(rst_n), .trig_out_i(tout),
    .irq_i(irq), .step_i(step_irq), .wdog_i(wdog_irq), .trig_in_o(tin));
  // -------------------------------
  // Shared tasks
  // -------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // A gap edge after each strobe keeps drivers to one assignment per step
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [15:0] exp);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
    @(posedge clk);
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    addr <= 6'h00;
    wdata <= 16'h0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic q(input logic [7:0] s0, input logic [7:0] s1, input logic [7:0] s2);
    wr_reg(QUEUE_OFS, {8'h00, s0});
    wr_reg(QUEUE_OFS + 6'h01, {8'h00, s1});
    wr_reg(QUEUE_OFS + 6'h02, {8'h00, s2});
  endtask
  task automatic wait_cnt(input int sel, input int n);
    int k;
    k = 0;
    while (u_pts_periph_model.cnt(sel) < n) begin
      @(posedge clk);
      k++;
      if (k > 3000) begin
        bad_count++;
        end_sim();
      end
    end
  endtask
  // -------------------------------
  // Scenarios
  // -------------------------------
  task automatic t_regs();
    do_reset();
    rd_chk(T0LIM_OFS, 16'h0000);
    rd_chk(T1LIM_OFS, 16'h0000);
    rd_chk(WDOG_OFS, WDOG_RESET);
    wr_reg(T0LIM_OFS, 16'h1234);
    wr_reg(T1LIM_OFS, 16'hABCD);
    wr_reg(6'h0A, 16'hFFFF);
    rd_chk(T0LIM_OFS, 16'h1234);
    rd_chk(T1LIM_OFS, 16'hABCD);
    rd_chk(6'h0A, 16'h0000);
    $display("t_regs done");
  endtask
  // A no-op step sits between the two triggers
  task automatic t_trig();
    do_reset();
    q(8'h43, 8'h00, 8'h45);
    wr_reg(QUEUE_OFS + 6'h03, 16'h0080);
    wr_reg(CTRL_OFS, 16'h0003);
    wait_cnt(5, 1);
    check(16'(u_pts_periph_model.cnt(3)), 16'h0001);
    repeat (4) @(posedge clk);
    rd_chk(CTRL_OFS, 16'h0001);
    $display("t_trig done");
  endtask
  task automatic t_timers();
    int n;
    do_reset();
    wr_reg(T0LIM_OFS, 16'h0005);
    wr_reg(T1LIM_OFS, 16'h0009);
    q(8'h10, 8'h20, 8'h41);
    wr_reg(QUEUE_OFS + 6'h03, 16'h0080);
    wr_reg(CTRL_OFS, 16'h0003);
    wr_reg(T0LIM_OFS, 16'h0077);
    wr_reg(T1LIM_OFS, 16'h0033);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (tout[1] !== 1'b1 && n < 200);
    check(16'(n), 16'h0010);
    @(posedge clk);
    repeat (3) @(posedge clk);
    rd_chk(T0LIM_OFS, 16'h0005);
    rd_chk(T1LIM_OFS, 16'h0009);
    $display("t_timers done");
  endtask
  // A wrong-kind edge comes first and must be ignored
  task automatic t_edge(input logic fall);
    u_pts_periph_model.set_in(2, !fall);
    do_reset();
    wr_reg(EDGE_OFS, fall ? 16'h0004 : 16'h0000);
    q(8'h32, 8'h47, 8'h80);
    wr_reg(CTRL_OFS, 16'h0003);
    repeat (4) @(posedge clk);
    u_pts_periph_model.set_in(2, fall);
    repeat (4) @(posedge clk);
    check(16'(u_pts_periph_model.cnt(7)), 16'h0000);
    u_pts_periph_model.set_in(2, !fall);
    wait_cnt(7, 1);
    check(16'(u_pts_periph_model.cnt(7)), 16'h0001);
    $display("t_edge done");
  endtask
  task automatic t_step();
    do_reset();
    q(8'h52, 8'h42, 8'h80);
    wr_reg(CTRL_OFS, 16'h0007);
    wait_cnt(20, 1);
    check(16'(u_pts_periph_model.cnt(18)), 16'h0001);
    repeat (10) @(posedge clk);
    check(16'(u_pts_periph_model.cnt(2)), 16'h0000);
    rd_chk(STATUS_OFS, {10'h000, ST_PAUSE, 4'h1});
    wr_reg(CTRL_OFS, 16'h0007);
    wait_cnt(2, 1);
    check(16'(u_pts_periph_model.cnt(20)), 16'h0002);
    $display("t_step done");
  endtask
  task automatic t_wdog();
    do_reset();
    wr_reg(WDOG_OFS, 16'h0014);
    q(8'h3F, 8'h80, 8'h80);
    wr_reg(CTRL_OFS, 16'h000B);
    wait_cnt(21, 1);
    repeat (2) @(posedge clk);
    rd_chk(CTRL_OFS, 16'h0009);
    $display("t_wdog done");
  endtask
  task automatic t_count(input logic [5:0] ofs, input logic [7:0] op);
    do_reset();
    wr_reg(ofs, 16'h0003);
    q(8'h41, op, 8'h80);
    wr_reg(CTRL_OFS, 16'h0003);
    wait_cnt(1, 4);
    repeat (20) @(posedge clk);
    check(16'(u_pts_periph_model.cnt(1)), 16'h0004);
    $display("t_count done");
  endtask
  initial begin
    t_regs();
    t_trig();
    t_timers();
    t_edge(1'b0);
    t_edge(1'b1);
    t_step();
    t_wdog();
    t_count(C0LIM_OFS, 8'h60);
    t_count(C1LIM_OFS, 8'h70);
    end_sim();
  end
endmodule
